// *** dmac_data_memory.sv ***
`timescale 1ns/1ns
// Summary of operation
// - 256-byte internal RAM, two 128-byte halves
// - Lower half reached directly and indirectly
// - 80H-FFH: indirect to RAM, direct to registers
// - 00H-1FH hold four banks of eight registers
// - Bank select bits pick bank base address
// - 20H-2FH byte and bit accessible
// - 30H-FFH user storage and stack
// - Stack pointer resets to 07H
// - Push increments pointer, then writes
// - Internal moves leave bus pins untouched
// - Expansion RAM 8192, 4096 or 2048 bytes
// - Eight-bit pointer moves hit 0000H-00FFH
// - Select 0: internal, overflow goes external
// - Select 1: every move goes external
// - External 64KB access with latch and strobes
// - Pin code places read/write strobes
// - Two-bit field sets setup and hold
module dmac_data_memory #(
    parameter int XRAM_BYTES = dmac_pkg::XRAM_BYTES_DEF
) (
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic                req_valid,
    input  wire dmac_pkg::dmac_req_s req,
    input  wire logic                acc_parity,
    output logic                     req_ready,
    output logic [7:0]               rdata,
    output logic                     rvalid,
    output logic [7:0]               stack_top_pointer,
    output logic [1:0]               bank_select,
    output logic [7:0]               low_address_data_port_o,
    output logic                     low_address_data_port_oe,
    input  wire logic [7:0]          low_address_data_port_i,
    output logic [7:0]               high_address_port,
    output logic                     address_latch,
    output logic [2:0]               read_strobe_n,
    output logic [2:0]               write_strobe_n,
    output logic [2:0]               strobe_oe
);

    localparam int XAW = $clog2(XRAM_BYTES);

    // ********************
    // Elaboration check
    // ********************
    generate
        if (XRAM_BYTES != 8192 && XRAM_BYTES != 4096 &&
            XRAM_BYTES != 2048) begin : g_bad_size
            $error("XRAM_BYTES must be 8192, 4096 or 2048");
        end
    endgenerate

    // ********************
    // State
    // ********************
    typedef struct packed {
        logic [7:0]             sp;
        logic [7:0]             program_status_word;
        logic [7:0]             auxiliary_control;
        logic [7:0]             bus;
        logic [7:0]             rdata;
        logic                   rvalid;
        dmac_pkg::dmac_xstate_e fsm;
        logic [1:0]             cnt;
        logic [15:0]            xaddr;
        logic [7:0]             xwdata;
        logic                   xwe;
        logic [7:0]             lad_out;
        logic                   lad_oe;
        logic [7:0]             hi;
        logic                   latch;
        logic                   rd_act;
        logic                   wr_act;
    } dmac_state_s;

    dmac_state_s st_reg;
    dmac_state_s st_next;

    logic [7:0]     iram_addr;
    logic           iram_we;
    logic [7:0]     iram_wdata;
    logic [7:0]     iram_rdata;
    logic [XAW-1:0] xram_addr;
    logic           xram_we;
    logic [7:0]     xram_wdata;
    logic [7:0]     xram_rdata;

    // ********************
    // Storage
    // ********************
    // Upper half is apart from the registers
    dmac_iram u_iram (
        .clk   (clk),
        .addr  (iram_addr),
        .we    (iram_we),
        .wdata (iram_wdata),
        .rdata (iram_rdata)
    );

    dmac_xram #(
        .BYTES (XRAM_BYTES),
        .AW    (XAW)
    ) u_xram (
        .clk   (clk),
        .addr  (xram_addr),
        .we    (xram_we),
        .wdata (xram_wdata),
        .rdata (xram_rdata)
    );

    // ********************
    // Special register read view
    // ********************
    function automatic logic [7:0] sfr_read(
        input logic [7:0] a,
        input logic [7:0] sp,
        input logic [7:0] program_status_word,
        input logic [7:0] auxiliary_control,
        input logic [7:0] bus,
        input logic       par
    );
        logic [7:0] v;
        v = 8'h00;
        case (a)
            dmac_pkg::SFR_AUXILIARY:   v = auxiliary_control;
            dmac_pkg::SFR_BUS_TIMING:  v = bus;
            dmac_pkg::SFR_STATUS_WORD: v = {program_status_word[7:2], 1'b0, par};
            dmac_pkg::SFR_STACK_TOP:   v = sp;
            default:                   v = 8'h00;
        endcase
        return v;
    endfunction : sfr_read

    // ********************
    // Next-state logic
    // ********************
    logic [7:0]  sfr_waddr;
    logic [7:0]  sfr_wdata;
    logic        sfr_we;
    logic [7:0]  old_byte;
    logic [7:0]  new_byte;
    logic [7:0]  sp_inc;
    logic [15:0] xa;
    logic [1:0]  speed;
    logic        ext_sel;

    always_comb begin
        st_next    = st_reg;
        st_next.rvalid = 1'b0;
        iram_addr  = 8'h00;
        iram_we    = 1'b0;
        iram_wdata = 8'h00;
        xram_addr  = '0;
        xram_we    = 1'b0;
        xram_wdata = 8'h00;
        sfr_waddr  = 8'h00;
        sfr_wdata  = 8'h00;
        sfr_we     = 1'b0;
        old_byte   = 8'h00;
        new_byte   = 8'h00;
        sp_inc     = st_reg.sp + 8'h01;
        xa         = req.ptr8 ? {dmac_pkg::PAGE_HIGH, req.addr[7:0]}
                              : req.addr;
        speed      = st_reg.bus[dmac_pkg::SPEED_MSB:dmac_pkg::SPEED_LSB];
        ext_sel    = st_reg.auxiliary_control[dmac_pkg::EXT_SEL_BIT];

        // Requests are taken only while no external cycle runs
        if (st_reg.fsm == dmac_pkg::ST_IDLE && req_valid) begin
            st_next.rvalid = 1'b1;
            case (req.op)
                dmac_pkg::OP_DIRECT: begin
                    if (!req.addr[7]) begin
                        iram_addr     = req.addr[7:0];
                        iram_we       = req.we;
                        iram_wdata    = req.wdata;
                        st_next.rdata = iram_rdata;
                    end else begin
                        // Direct upper addresses are registers
                        st_next.rdata = sfr_read(req.addr[7:0],
                            st_reg.sp, st_reg.program_status_word, st_reg.auxiliary_control,
                            st_reg.bus, acc_parity);
                        sfr_we    = req.we;
                        sfr_waddr = req.addr[7:0];
                        sfr_wdata = req.wdata;
                    end
                end
                dmac_pkg::OP_INDIRECT: begin
                    // Indirect reaches all 256 bytes of RAM
                    iram_addr     = req.addr[7:0];
                    iram_we       = req.we;
                    iram_wdata    = req.wdata;
                    st_next.rdata = iram_rdata;
                end
                dmac_pkg::OP_REGISTER: begin
                    iram_addr  = {3'b000,
                                  st_reg.program_status_word[dmac_pkg::BANK_HI_BIT],
                                  st_reg.program_status_word[dmac_pkg::BANK_LO_BIT],
                                  req.addr[2:0]};
                    iram_we       = req.we;
                    iram_wdata    = req.wdata;
                    st_next.rdata = iram_rdata;
                end
                dmac_pkg::OP_BIT: begin
                    if (!req.addr[7]) begin
                        iram_addr = dmac_pkg::BIT_AREA_BASE +
                                    {4'h0, req.addr[6:3]};
                        old_byte  = iram_rdata;
                    end else begin
                        // Upper bit addresses fall on register bytes
                        old_byte = sfr_read({req.addr[7:3], 3'b000},
                            st_reg.sp, st_reg.program_status_word, st_reg.auxiliary_control,
                            st_reg.bus, acc_parity);
                    end
                    new_byte = old_byte;
                    new_byte[req.addr[2:0]] = req.wdata[0];
                    st_next.rdata = {7'h00, old_byte[req.addr[2:0]]};
                    if (req.we && !req.addr[7]) begin
                        iram_we    = 1'b1;
                        iram_wdata = new_byte;
                    end
                    if (req.we && req.addr[7]) begin
                        sfr_we    = 1'b1;
                        sfr_waddr = {req.addr[7:3], 3'b000};
                        sfr_wdata = new_byte;
                    end
                end
                dmac_pkg::OP_PUSH: begin
                    // Pointer moves up first, byte lands above
                    iram_addr  = sp_inc;
                    iram_we    = 1'b1;
                    iram_wdata = req.wdata;
                    st_next.sp = sp_inc;
                    st_next.rdata = req.wdata;
                end
                dmac_pkg::OP_POP: begin
                    iram_addr     = st_reg.sp;
                    st_next.rdata = iram_rdata;
                    st_next.sp    = st_reg.sp - 8'h01;
                end
                dmac_pkg::OP_XMOVE: begin
                    if (!ext_sel &&
                        ({1'b0, xa} < 17'(XRAM_BYTES))) begin
                        // Internal move: bus pins keep their state
                        xram_addr     = xa[XAW-1:0];
                        xram_we       = req.we;
                        xram_wdata    = req.wdata;
                        st_next.rdata = xram_rdata;
                    end else begin
                        // Beyond capacity or disabled: go off chip
                        st_next.rvalid = 1'b0;
                        st_next.fsm    = dmac_pkg::ST_LATCH;
                        st_next.xaddr  = xa;
                        st_next.xwe    = req.we;
                        st_next.xwdata = req.wdata;
                        st_next.cnt    = 2'h0;
                    end
                end
                default: begin
                    st_next.rvalid = 1'b0;
                end
            endcase
        end

        // Register writes; reserved bits are masked away
        if (sfr_we) begin
            case (sfr_waddr)
                dmac_pkg::SFR_AUXILIARY:   st_next.auxiliary_control = sfr_wdata;
                dmac_pkg::SFR_BUS_TIMING:
                    st_next.bus = sfr_wdata & dmac_pkg::BUS_WMASK;
                dmac_pkg::SFR_STATUS_WORD:
                    st_next.program_status_word = sfr_wdata & dmac_pkg::STATUS_WMASK;
                dmac_pkg::SFR_STACK_TOP:   st_next.sp = sfr_wdata;
                default:                   st_next.sp = st_next.sp;
            endcase
        end

        // External cycle sequencer
        case (st_reg.fsm)
            dmac_pkg::ST_IDLE: begin
                st_next.cnt = st_next.cnt;
            end
            dmac_pkg::ST_LATCH: begin
                st_next.fsm = dmac_pkg::ST_SETUP;
                st_next.cnt = 2'h0;
            end
            dmac_pkg::ST_SETUP: begin
                // Setup, strobe and hold each last speed+1 cycles; latch lasts one
                if (st_reg.cnt == speed) begin
                    st_next.fsm = dmac_pkg::ST_STROBE;
                    st_next.cnt = 2'h0;
                end else begin
                    st_next.cnt = st_reg.cnt + 2'h1;
                end
            end
            dmac_pkg::ST_STROBE: begin
                if (st_reg.cnt == speed) begin
                    st_next.fsm = dmac_pkg::ST_HOLD;
                    st_next.cnt = 2'h0;
                    // Sample read data as the strobe ends
                    if (!st_reg.xwe) begin
                        st_next.rdata = low_address_data_port_i;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt + 2'h1;
                end
            end
            dmac_pkg::ST_HOLD: begin
                if (st_reg.cnt == speed) begin
                    st_next.fsm    = dmac_pkg::ST_IDLE;
                    st_next.cnt    = 2'h0;
                    st_next.rvalid = 1'b1;
                end else begin
                    st_next.cnt = st_reg.cnt + 2'h1;
                end
            end
            default: begin
                st_next.fsm = dmac_pkg::ST_IDLE;
                st_next.cnt = 2'h0;
            end
        endcase

        // Pin values follow the phase about to start
        st_next.latch  = 1'b0;
        st_next.rd_act = 1'b0;
        st_next.wr_act = 1'b0;
        case (st_next.fsm)
            dmac_pkg::ST_LATCH: begin
                st_next.lad_out = st_next.xaddr[7:0];
                st_next.lad_oe  = 1'b1;
                st_next.hi      = st_next.xaddr[15:8];
                st_next.latch   = 1'b1;
            end
            dmac_pkg::ST_SETUP,
            dmac_pkg::ST_HOLD: begin
                st_next.lad_out = st_next.xwdata;
                st_next.lad_oe  = st_next.xwe;
            end
            dmac_pkg::ST_STROBE: begin
                st_next.lad_out = st_next.xwdata;
                st_next.lad_oe  = st_next.xwe;
                st_next.rd_act  = !st_next.xwe;
                st_next.wr_act  = st_next.xwe;
            end
            default: begin
                // Idle: release the data lines, address stays put
                st_next.lad_oe = 1'b0;
            end
        endcase
    end

    // ********************
    // State register
    // ********************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_reg        <= '0;
            st_reg.sp     <= dmac_pkg::STACK_RESET;
            st_reg.program_status_word    <= dmac_pkg::STATUS_RESET;
            st_reg.auxiliary_control   <= dmac_pkg::AUXILIARY_RESET;
            st_reg.bus    <= dmac_pkg::BUS_RESET;
            st_reg.fsm    <= dmac_pkg::ST_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ********************
    // Outputs
    // ********************
    // Ready decodes the registered state, so it drops the cycle after an external move is taken
    assign req_ready                = (st_reg.fsm == dmac_pkg::ST_IDLE);
    assign rdata                    = st_reg.rdata;
    assign rvalid                   = st_reg.rvalid;
    assign stack_top_pointer        = st_reg.sp;
    assign bank_select              = st_reg.program_status_word[dmac_pkg::BANK_HI_BIT:
                                                 dmac_pkg::BANK_LO_BIT];
    assign low_address_data_port_o  = st_reg.lad_out;
    assign low_address_data_port_oe = st_reg.lad_oe;
    assign high_address_port        = st_reg.hi;
    assign address_latch            = st_reg.latch;

    // One strobe pair per pin code; the reserved code drives none
    logic [1:0] pin_sel;
    assign pin_sel = st_reg.bus[dmac_pkg::PIN_SEL_MSB:
                                dmac_pkg::PIN_SEL_LSB];

    genvar g;
    generate
        for (g = 0; g < dmac_pkg::STROBE_PAIRS; g++) begin : g_strobe
            assign strobe_oe[g]      = (pin_sel == 2'(g));
            assign read_strobe_n[g]  = !(strobe_oe[g] && st_reg.rd_act);
            assign write_strobe_n[g] = !(strobe_oe[g] && st_reg.wr_act);
        end
    endgenerate

endmodule : dmac_data_memory

// *** dmac_pkg.sv ***
package dmac_pkg;

    // ********************
    // Special register addresses (direct space, 80H and up)
    // ********************
    localparam logic [7:0] SFR_AUXILIARY   = 8'h8E;
    localparam logic [7:0] SFR_BUS_TIMING  = 8'hA1;
    localparam logic [7:0] SFR_STATUS_WORD = 8'hD0;
    localparam logic [7:0] SFR_STACK_TOP   = 8'h81;

    // ********************
    // Reset values and write masks
    // ********************
    localparam logic [7:0] STACK_RESET     = 8'h07;
    localparam logic [7:0] AUXILIARY_RESET = 8'h00;
    localparam logic [7:0] BUS_RESET       = 8'h00;
    localparam logic [7:0] STATUS_RESET    = 8'h00;
    localparam logic [7:0] BUS_WMASK       = 8'hC3;
    localparam logic [7:0] STATUS_WMASK    = 8'hFC;

    // ********************
    // Field positions and address map
    // ********************
    localparam int EXT_SEL_BIT   = 1;
    localparam int BANK_HI_BIT   = 4;
    localparam int BANK_LO_BIT   = 3;
    localparam int PIN_SEL_MSB   = 7;
    localparam int PIN_SEL_LSB   = 6;
    localparam int SPEED_MSB     = 1;
    localparam int SPEED_LSB     = 0;
    localparam int STROBE_PAIRS  = 3;
    localparam int XRAM_BYTES_DEF = 8192;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [7:0] PAGE_HIGH     = 8'h00;

    // Strobe pin codes
    localparam logic [1:0] PINS_P44_P43 = 2'h0;
    localparam logic [1:0] PINS_P37_P36 = 2'h1;
    localparam logic [1:0] PINS_P42_P40 = 2'h2;
    localparam logic [1:0] PINS_NONE    = 2'h3;

    // ********************
    // Operations, states and carriers
    // ********************
    typedef enum logic [6:0] {
        OP_DIRECT   = 7'h01,
        OP_INDIRECT = 7'h02,
        OP_REGISTER = 7'h04,
        OP_BIT      = 7'h08,
        OP_PUSH     = 7'h10,
        OP_POP      = 7'h20,
        OP_XMOVE    = 7'h40
    } dmac_op_e;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_LATCH  = 5'h02,
        ST_SETUP  = 5'h04,
        ST_STROBE = 5'h08,
        ST_HOLD   = 5'h10
    } dmac_xstate_e;

    typedef struct packed {
        dmac_op_e    op;
        logic        we;
        logic        ptr8;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } dmac_req_s;

endpackage : dmac_pkg

// *** dmac_iram.sv ***
`timescale 1ns/1ns
// ********************
// 256 x 8 internal RAM, combinational read, clocked write
// ********************
module dmac_iram (
    input  wire logic       clk,
    input  wire logic [7:0] addr,
    input  wire logic       we,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);

    logic [7:0] mem [0:255];

    // Async read: bit ops write back in one cycle
    assign rdata = mem[addr];

    // Write port; contents are not cleared by reset
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

endmodule : dmac_iram

// *** dmac_xram.sv ***
`timescale 1ns/1ns
// ********************
// Internal expansion RAM, size set by variant
// ********************
module dmac_xram #(
    parameter int BYTES = dmac_pkg::XRAM_BYTES_DEF,
    parameter int AW    = $clog2(BYTES)
) (
    input  wire logic          clk,
    input  wire logic [AW-1:0] addr,
    input  wire logic          we,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);

    logic [7:0] mem [0:BYTES-1];

    // Combinational read: internal moves take one cycle
    assign rdata = mem[addr];

    // Write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

endmodule : dmac_xram

// *** dmac_data_memory_chk.sv ***
`timescale 1ns/1ns
// ****************
// Port checks for the data memory block
// ****************
module dmac_data_memory_chk #(
    parameter int XRAM_BYTES = 8192
) (
    input wire logic                clk,
    input wire logic                reset_n,
    input wire logic                req_valid,
    input wire dmac_pkg::dmac_req_s req,
    input wire logic                req_ready,
    input wire logic                rvalid,
    input wire logic [7:0]          stack_top_pointer,
    input wire logic                low_address_data_port_oe,
    input wire logic                address_latch,
    input wire logic [2:0]          read_strobe_n,
    input wire logic [2:0]          write_strobe_n,
    input wire logic [2:0]          strobe_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Taken requests; overflow means external
    wire tk  = req_valid && req_ready;
    wire ext = tk && req.op == dmac_pkg::OP_XMOVE && !req.ptr8
        && req.addr >= XRAM_BYTES;
    a_sp_reset:
        assert property ($rose(reset_n) |-> stack_top_pointer == 8'h07)
        else $error("bad reset sp");
    a_push_up:
        assert property (tk && req.op == dmac_pkg::OP_PUSH |=>
            stack_top_pointer == $past(stack_top_pointer) + 8'h01)
        else $error("push sp wrong");
    a_pop_down:
        assert property (tk && req.op == dmac_pkg::OP_POP |=>
            stack_top_pointer == $past(stack_top_pointer) - 8'h01)
        else $error("pop sp wrong");
    a_int_quiet:
        assert property (tk && req.op != dmac_pkg::OP_XMOVE |=>
            !address_latch && !low_address_data_port_oe && &write_strobe_n)
        else $error("bus pins moved");
    a_int_done:
        assert property (tk && req.op != dmac_pkg::OP_XMOVE
            && $onehot(req.op) |=> rvalid)
        else $error("no rvalid");
    a_ext_latch:
        assert property (ext |=> address_latch && !req_ready)
        else $error("no latch");
    a_ext_done:
        assert property (ext |-> ##[5:14] (rvalid && req_ready))
        else $error("ext too slow");
    a_ext_busy:
        assert property (ext |=> !req_ready [*4])
        else $error("ready during ext");
    a_strobe_sel:
        assert property (((~read_strobe_n | ~write_strobe_n) & ~strobe_oe)
            == 3'h0 && $onehot0(strobe_oe))
        else $error("stray strobe");
endmodule : dmac_data_memory_chk

bind dmac_data_memory dmac_data_memory_chk #(.XRAM_BYTES(XRAM_BYTES)) chk_u (
    .clk, .reset_n, .req_valid, .req, .req_ready, .rvalid,
    .stack_top_pointer, .low_address_data_port_oe, .address_latch,
    .read_strobe_n, .write_strobe_n, .strobe_oe);

// *** dmac_xmem.sv ***
`timescale 1ns/1ns
// ****************
// Off-chip data memory on the shared bus
// ****************
module dmac_xmem (
    input wire logic       clk,
    input wire logic       slow,
    input wire logic       address_latch,
    input wire logic [7:0] low_address_data_port_o,
    input wire logic       low_address_data_port_oe,
    input wire logic [7:0] high_address_port,
    input wire logic [2:0] read_strobe_n,
    input wire logic [2:0] write_strobe_n,
    input wire logic [2:0] strobe_oe,
    output logic     [7:0] low_address_data_port_i
);
    logic [7:0] mem [65536];
    logic [7:0] lo_reg;
    logic [7:0] last = 8'h5A;
    int         n_low;
    wire rd = |(~read_strobe_n & strobe_oe);
    wire wr = |(~write_strobe_n & strobe_oe);
    // Slow part: data good after one strobe edge
    wire ok = rd && n_low >= int'(slow);
    // Latch address, store on write, time the read
    always @(posedge clk) begin
        if (address_latch) lo_reg <= low_address_data_port_o;
        if (wr && low_address_data_port_oe)
            mem[{high_address_port, lo_reg}] <= low_address_data_port_o;
        n_low <= rd ? n_low + 1 : 0;
        if (ok) last <= mem[{high_address_port, lo_reg}];
    end
    // Released bus shows inverse so stale data fails
    assign low_address_data_port_i =
        ok ? mem[{high_address_port, lo_reg}] : ~last;
endmodule : dmac_xmem

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    logic                clk, reset_n, req_valid, acc_parity, slow;
    dmac_pkg::dmac_req_s req;
    logic                req_ready, rvalid, address_latch;
    logic [7:0]          rdata, stack_top_pointer, high_address_port;
    logic [7:0]          low_address_data_port_o, low_address_data_port_i;
    logic                low_address_data_port_oe;
    logic [1:0]          bank_select;
    logic [2:0]          read_strobe_n, write_strobe_n, strobe_oe;
    logic [7:0]          r, d;
    logic [15:0]         a;
    int                  err_total, n_compared, lat, b, n;

    dmac_data_memory #(.XRAM_BYTES(8192)) dut_u (.*);
    dmac_xmem mem_u (.*);

    // ****************
    // Clock, checks and requests
    // ****************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    // One request, then a bounded wait for rvalid
    task op(input dmac_pkg::dmac_op_e o, input logic w, input logic p,
            input logic [15:0] ad, input logic [7:0] wd);
        @(posedge clk);
        req_valid <= 1'b1;
        req       <= '{o, w, p, ad, wd};
        @(posedge clk);
        req_valid <= 1'b0;
        #1 lat = 1;
        while (rvalid !== 1'b1 && lat < 20) begin
            @(posedge clk);
            #1 lat++;
        end
        if (rvalid !== 1'b1) begin
            err_total++;
            report_and_stop;
        end
        r = rdata;
    endtask : op
    task dw(input logic [7:0] ad, input logic [7:0] wd);
        op(dmac_pkg::OP_DIRECT, 1'b1, 1'b0, {8'h00, ad}, wd);
    endtask : dw
    task dr(input logic [7:0] ad);
        op(dmac_pkg::OP_DIRECT, 1'b0, 1'b0, {8'h00, ad}, 8'h00);
    endtask : dr
    function automatic logic [7:0] pins_exp(input int c);
        return (c == 3) ? 8'h00 : 8'h01 << c;
    endfunction : pins_exp

    // ****************
    // Main sequence
    // ****************
    initial begin
        void'($urandom(32'h1fc60aa5));
        reset_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        slow = 1'b0;
        acc_parity = 1'($urandom % 2);
        err_total = 0;
        n_compared = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        #1 chk(stack_top_pointer, 8'h07);
        chk({5'h00, strobe_oe}, 8'h01);
        dr(dmac_pkg::SFR_STATUS_WORD);
        chk(r, {7'h00, acc_parity});
        dw(8'hA2, 8'hFF);
        dr(8'hA2);
        chk(r, 8'h00);
        dw(dmac_pkg::SFR_BUS_TIMING, 8'hFF);
        dr(dmac_pkg::SFR_BUS_TIMING);
        chk(r, 8'hC3);
        // Stack grows upward from 08H
        op(dmac_pkg::OP_PUSH, 1'b1, 1'b0, 16'h0000, 8'hAA);
        chk(stack_top_pointer, 8'h08);
        dr(8'h08);
        chk(r, 8'hAA);
        op(dmac_pkg::OP_POP, 1'b0, 1'b0, 16'h0000, 8'h00);
        chk(r, 8'hAA);
        dw(dmac_pkg::SFR_STACK_TOP, 8'h80);
        chk(stack_top_pointer, 8'h80);
        // Each bank maps register five to its own byte
        for (b = 0; b < 4; b++) begin
            d = 8'($urandom);
            dw(dmac_pkg::SFR_STATUS_WORD, {3'h0, b[1:0], 3'h0});
            chk({6'h00, bank_select}, 8'(b));
            op(dmac_pkg::OP_REGISTER, 1'b1, 1'b0, 16'h0005, d);
            dr(8'(b * 8 + 5));
            chk(r, d);
        end
        // Upper half and registers share addresses, not storage
        op(dmac_pkg::OP_INDIRECT, 1'b1, 1'b0, 16'h008E, 8'h5A);
        dr(8'h8E);
        chk(r, 8'h00);
        op(dmac_pkg::OP_INDIRECT, 1'b0, 1'b0, 16'h008E, 8'h00);
        chk(r, 8'h5A);
        dw(8'h40, 8'h3C);
        op(dmac_pkg::OP_INDIRECT, 1'b0, 1'b0, 16'h0040, 8'h00);
        chk(r, 8'h3C);
        // Random bit addresses land in the bit area
        repeat (8) begin
            n = $urandom % 128;
            dw(8'(32'h20 + n / 8), 8'h00);
            op(dmac_pkg::OP_BIT, 1'b1, 1'b0, 16'(n), 8'h01);
            dr(8'(32'h20 + n / 8));
            chk(r, 8'h01 << (n % 8));
            op(dmac_pkg::OP_BIT, 1'b0, 1'b0, 16'(n), 8'h00);
            chk(r, 8'h01);
        end
        // Expansion RAM, short pointer, forced external
        a = 16'($urandom % 8192);
        d = 8'($urandom);
        op(dmac_pkg::OP_XMOVE, 1'b1, 1'b0, a, d);
        chk(8'(lat), 8'h01);
        op(dmac_pkg::OP_XMOVE, 1'b0, 1'b0, a, 8'h00);
        chk(r, d);
        op(dmac_pkg::OP_XMOVE, 1'b1, 1'b1, 16'h1234, 8'h66);
        op(dmac_pkg::OP_XMOVE, 1'b0, 1'b0, 16'h0034, 8'h00);
        chk(r, 8'h66);
        dw(dmac_pkg::SFR_BUS_TIMING, 8'h00);
        dw(dmac_pkg::SFR_AUXILIARY, 8'h02);
        op(dmac_pkg::OP_XMOVE, 1'b1, 1'b0, 16'h0034, 8'h99);
        chk(mem_u.mem[16'h0034], 8'h99);
        dw(dmac_pkg::SFR_AUXILIARY, 8'h00);
        op(dmac_pkg::OP_XMOVE, 1'b0, 1'b0, 16'h0034, 8'h00);
        chk(r, 8'h66);
        // Each pin code, random speed, external address
        for (b = 0; b < 4; b++) begin
            n = $urandom % 4;
            slow = (n != 0);
            dw(dmac_pkg::SFR_BUS_TIMING, {b[1:0], 4'h0, n[1:0]});
            chk({5'h00, strobe_oe}, pins_exp(b));
            a = 16'h2000 + 16'($urandom % 32'hE000);
            d = 8'($urandom);
            op(dmac_pkg::OP_XMOVE, 1'b1, 1'b0, a, d);
            chk(8'(lat), 8'(3 * n + 5));
            op(dmac_pkg::OP_XMOVE, 1'b0, 1'b0, a, 8'h00);
            if (b != 3) chk(r, d);
        end
        report_and_stop;
    end
endmodule : tb_top
